// *** shared/hsirq_defs.svh ***
// Register offsets, field positions, reset values for the haptic status/interrupt registers.
// Assumes an 8-bit register address space reached by the serial control bus front end.
`ifndef HSIRQ_DEFS_SVH
`define HSIRQ_DEFS_SVH

`define HSIRQ_ADDR_STATUS      8'h01
`define HSIRQ_ADDR_MASK        8'h02
`define HSIRQ_ADDR_IMPEDANCE   8'h03
`define HSIRQ_ADDR_SUPPLY      8'h04

`define HSIRQ_BIT_OVERCURRENT  0
`define HSIRQ_BIT_THERMAL      1
`define HSIRQ_BIT_DROOP        2
`define HSIRQ_BIT_DONE         3
`define HSIRQ_BIT_RAM_ERR      4
`define HSIRQ_BIT_DIAG_FAIL    7
`define HSIRQ_RSV_LO           5
`define HSIRQ_RSV_HI           6

`define HSIRQ_MASK_RESET       5'h18
`define HSIRQ_STATUS_RESET     8'h00
`define HSIRQ_IMPEDANCE_RESET  8'h00
`define HSIRQ_SUPPLY_RESET     8'h00

`endif

// *** shared/hsirq_pkg.sv ***
// Types shared by the haptic status/interrupt register block.
// Assumes the offsets and reset values live in hsirq_defs.svh.
package hsirq_pkg;

	// Trigger pin function selection
	typedef enum logic [1:0] {
		HSIRQ_PIN_EXT_PULSE,
		HSIRQ_PIN_EXT_LEVEL,
		HSIRQ_PIN_IRQ,
		HSIRQ_PIN_RSVD
	} hsirq_pin_func_type;

	// One-cycle event pulses from the engine, diagnostics and protection
	typedef struct packed {
		logic diag_fail;
		logic ram_format_error;
		logic done;
		logic supply_droop;
		logic thermal;
		logic overcurrent;
	} hsirq_event_type;

	// Register access from the serial bus front end
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hsirq_bus_req_type;

	// Measurement results
	typedef struct packed {
		logic       impedance_valid;
		logic [7:0] impedance;
		logic       playing;
		logic       supply_valid;
		logic [7:0] supply;
	} hsirq_meas_type;

endpackage : hsirq_pkg

// *** tb/haptic_status_irq_regs_tb_top.sv ***
// Self-checking bench for the status, mask and result registers.
// Assumes the host model drives the bus and resolves the interrupt wire.
`timescale 1ns/1ps
`include "hsirq_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; $display("mismatch %0t value", $time); end end

module haptic_status_irq_regs_tb_top;
	logic                              clk_sys;
	logic                              rstn;
	logic                              ce;
	hsirq_pkg::hsirq_bus_req_type      bus_req;
	logic [7:0]                        rdata_q;
	hsirq_pkg::hsirq_event_type        events;
	hsirq_pkg::hsirq_meas_type         meas;
	hsirq_pkg::hsirq_pin_func_type     pin_func;
	logic                              pin_o;
	logic                              pin_oe;
	logic                              pin_level;
	logic                              irq_act;
	logic [7:0]                        rd_data;
	logic [5:0]                        ev;
	integer                            err_total = 0;
	integer                            comparisons = 0;
	integer                            cycles = 0;

	hsirq_regs dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .bus_req(bus_req), .rdata_q(rdata_q),
		.events(events), .meas(meas), .pin_func(pin_func), .trigger_irq_pin_o(pin_o),
		.trigger_irq_pin_oe(pin_oe), .irq_active(irq_act));
	hsirq_host_model host_u (.clk_sys(clk_sys), .bus_req(bus_req), .rdata_q(rdata_q), .pin_o(pin_o),
		.pin_oe(pin_oe), .pin_level(pin_level));

	// Clock at 40 MHz
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Ceiling on run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (err_total == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.access(1'b1, a, d, rd_data);
	endtask : wr

	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		host_u.access(1'b0, a, 8'h00, rd_data);
		`CHK(rd_data, e)
	endtask : rd_exp

	// One-cycle event pulse
	task automatic pulse(input logic [5:0] e);
		@(negedge clk_sys);
		events = e;
		@(negedge clk_sys);
		events = '0;
	endtask : pulse

	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		events = '0;
		meas = '0;
		pin_func = hsirq_pkg::HSIRQ_PIN_EXT_PULSE;
		repeat (12) @(negedge clk_sys);
		rstn = 1'b1;
		rd_exp(`HSIRQ_ADDR_MASK, 8'h18);
		rd_exp(`HSIRQ_ADDR_IMPEDANCE, 8'h00);
		rd_exp(`HSIRQ_ADDR_SUPPLY, 8'h00);
		rd_exp(`HSIRQ_ADDR_STATUS, 8'h00);
		rd_exp(8'h7E, 8'h00);
		// Each flag sets, reads back once, then is gone
		for (int i = 0; i < 6; i++) begin
			ev = 6'h01 << i;
			pulse(ev);
			rd_exp(`HSIRQ_ADDR_STATUS, {ev[5], 2'b00, ev[4:0]});
			rd_exp(`HSIRQ_ADDR_STATUS, 8'h00);
		end
		// Interrupt mode: unmasked flag pulls the wire low until read
		pin_func = hsirq_pkg::HSIRQ_PIN_IRQ;
		for (int i = 0; i < 5; i++) begin
			ev = 6'h01 << i;
			wr(`HSIRQ_ADDR_MASK, 8'h00);
			pulse(ev);
			`CHK(pin_level, 1'b0)
			`CHK(irq_act, 1'b1)
			rd_exp(`HSIRQ_ADDR_STATUS, {3'b000, ev[4:0]});
			`CHK(pin_level, 1'b1)
			`CHK(irq_act, 1'b0)
			wr(`HSIRQ_ADDR_MASK, {3'b000, ev[4:0]});
			pulse(ev);
			`CHK(pin_level, 1'b1)
			rd_exp(`HSIRQ_ADDR_STATUS, {3'b000, ev[4:0]});
		end
		// Other pin functions never signal, mask cleared
		wr(`HSIRQ_ADDR_MASK, 8'h00);
		for (int f = 0; f < 4; f++) begin
			if (f != 2) begin
				pin_func = hsirq_pkg::hsirq_pin_func_type'(f);
				pulse(6'h01);
				`CHK(pin_level, 1'b1)
				rd_exp(`HSIRQ_ADDR_STATUS, 8'h01);
			end
		end
		wr(`HSIRQ_ADDR_MASK, 8'hE7);
		rd_exp(`HSIRQ_ADDR_MASK, 8'hE7);
		// Impedance capture; writes to it are ignored
		@(negedge clk_sys);
		meas.impedance = 8'hA5;
		meas.impedance_valid = 1'b1;
		@(negedge clk_sys);
		meas.impedance_valid = 1'b0;
		meas.impedance = 8'h5A;
		rd_exp(`HSIRQ_ADDR_IMPEDANCE, 8'hA5);
		wr(`HSIRQ_ADDR_IMPEDANCE, 8'h3C);
		rd_exp(`HSIRQ_ADDR_IMPEDANCE, 8'hA5);
		// Supply reading taken only while playing
		@(negedge clk_sys);
		meas.supply = 8'h5C;
		meas.supply_valid = 1'b1;
		@(negedge clk_sys);
		rd_exp(`HSIRQ_ADDR_SUPPLY, 8'h00);
		meas.playing = 1'b1;
		@(negedge clk_sys);
		meas.playing = 1'b0;
		meas.supply = 8'hA3;
		rd_exp(`HSIRQ_ADDR_SUPPLY, 8'h5C);
		// Event while frozen is not taken; event during a status read survives it
		@(negedge clk_sys);
		ce = 1'b0;
		pulse(6'h08);
		ce = 1'b1;
		rd_exp(`HSIRQ_ADDR_STATUS, 8'h00);
		fork
			pulse(6'h08);
			rd_exp(`HSIRQ_ADDR_STATUS, 8'h00);
		join
		rd_exp(`HSIRQ_ADDR_STATUS, 8'h08);
		// Status reserved bits are stored, flag bits ignore writes
		wr(`HSIRQ_ADDR_STATUS, 8'hFF);
		rd_exp(`HSIRQ_ADDR_STATUS, 8'h60);
		give_verdict();
	end
endmodule : haptic_status_irq_regs_tb_top

// *** tb/hsirq_host_model.sv ***
// Host side model: register bus master and the pulled-up interrupt wire.
// Assumes one-cycle strobes and read data valid one cycle after the strobe.
`timescale 1ns/1ps

module hsirq_host_model (
	input  wire logic                    clk_sys,
	output hsirq_pkg::hsirq_bus_req_type bus_req,
	input  wire logic [7:0]              rdata_q,
	input  wire logic                    pin_o,
	input  wire logic                    pin_oe,
	output logic                         pin_level
);
	// Open drain wire, pulled up while nobody drives it
	assign pin_level = pin_oe ? pin_o : 1'b1;

	initial bus_req = '0;

	// One bus cycle launched at a falling edge; released fields go inverse
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] data);
		@(negedge clk_sys);
		bus_req = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
		@(negedge clk_sys);
		bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
		data = rdata_q;
	endtask : access
endmodule : hsirq_host_model

// *** verilog/hsirq_regs.sv ***
// Status flags, interrupt mask, impedance and supply result registers of the haptic driver.
// Assumes a serial bus front end issuing one-cycle rd/wr strobes and taking rdata the next cycle.
`timescale 1ns/1ps
`include "hsirq_defs.svh"

// Notes on behaviour
// - Completion flag sets when sequencer, diagnostics or calibration finish; clears on status read.
// - Supply droop flag latches below threshold, stays set, clears on status read.
// - Thermal flag latches on over-temperature, stays set, clears on status read.
// - Overcurrent flag latches on either output, stays set, clears on status read.
// - Five-bit mask, a one suppresses that flag's interrupt; resets to 24.
// - Mask matters only when the trigger pin is set to interrupt function.
// - Eight-bit impedance result updated by diagnostics, readable, resets to zero.
// - Eight-bit supply reading refreshed only while a waveform plays.
// - RAM format error flag latches on bad RAM content, clears on status read.
// - Diagnostic failure flag latches on open, short or calibration failure; clears on read.
module hsirq_regs (
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	input  wire logic                        ce,
	input  wire hsirq_pkg::hsirq_bus_req_type bus_req,
	output logic [7:0]                       rdata_q,
	input  wire hsirq_pkg::hsirq_event_type   events,
	input  wire hsirq_pkg::hsirq_meas_type    meas,
	input  wire hsirq_pkg::hsirq_pin_func_type pin_func,
	output logic                             trigger_irq_pin_o,
	output logic                             trigger_irq_pin_oe,
	output logic                             irq_active
);

	logic [4:0] irq_suppress_bits_q;
	logic [1:0] status_rsv_q;
	logic [2:0] mask_rsv_q;
	logic [7:0] actuator_impedance_result_q;
	logic [7:0] supply_voltage_level_q;
	logic       output_overcurrent_flag;
	logic       thermal_flag;
	logic       supply_droop_flag;
	logic       done_flag;
	logic       ram_format_error_flag;
	logic       diag_fail_flag;
	logic [7:0] status_word;
	logic [4:0] irq_sources;
	logic       irq_mode;
	logic       status_rd;
	logic       status_wr;
	logic       mask_wr;
	logic [7:0] rdata_d;

	// Address decode helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction : hit

	// Access strobes
	assign status_rd = bus_req.rd & hit(bus_req.addr, `HSIRQ_ADDR_STATUS);
	assign status_wr = bus_req.wr & hit(bus_req.addr, `HSIRQ_ADDR_STATUS);
	assign mask_wr   = bus_req.wr & hit(bus_req.addr, `HSIRQ_ADDR_MASK);

	// Sticky status flags, each cleared by a status read
	hsirq_sticky u_oc (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.set     (events.overcurrent),
		.clr     (status_rd),
		.flag_q  (output_overcurrent_flag)
	);
	hsirq_sticky u_ot (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.set     (events.thermal),
		.clr     (status_rd),
		.flag_q  (thermal_flag)
	);
	hsirq_sticky u_uv (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.set     (events.supply_droop),
		.clr     (status_rd),
		.flag_q  (supply_droop_flag)
	);
	hsirq_sticky u_done (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.set     (events.done),
		.clr     (status_rd),
		.flag_q  (done_flag)
	);
	hsirq_sticky u_ram (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.set     (events.ram_format_error),
		.clr     (status_rd),
		.flag_q  (ram_format_error_flag)
	);
	hsirq_sticky u_diag (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.set     (events.diag_fail),
		.clr     (status_rd),
		.flag_q  (diag_fail_flag)
	);

	// Status word as the host sees it
	assign status_word = {diag_fail_flag, status_rsv_q, ram_format_error_flag,
		done_flag, supply_droop_flag, thermal_flag, output_overcurrent_flag};

	// Interrupt sources: unmasked flags of bits 0-4 (diag fail never interrupts), mask honoured only in interrupt mode
	assign irq_mode    = (pin_func == hsirq_pkg::HSIRQ_PIN_IRQ);
	assign irq_sources = status_word[4:0] & ~irq_suppress_bits_q;
	assign irq_active  = irq_mode & (|irq_sources);
	// Open-drain active-low pin: driving means pulling low
	assign trigger_irq_pin_o  = 1'b0;
	assign trigger_irq_pin_oe = irq_active;

	// Writable registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			irq_suppress_bits_q <= `HSIRQ_MASK_RESET;
			mask_rsv_q          <= 3'h0;
			status_rsv_q        <= 2'h0;
		end else if (ce) begin
			if (mask_wr) begin
				irq_suppress_bits_q <= bus_req.wdata[4:0];
				mask_rsv_q          <= bus_req.wdata[7:5];
			end
			if (status_wr) begin
				status_rsv_q <= bus_req.wdata[`HSIRQ_RSV_HI:`HSIRQ_RSV_LO];
			end
		end
	end

	// Measurement result registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			actuator_impedance_result_q <= `HSIRQ_IMPEDANCE_RESET;
			supply_voltage_level_q      <= `HSIRQ_SUPPLY_RESET;
		end else if (ce) begin
			if (meas.impedance_valid) begin
				actuator_impedance_result_q <= meas.impedance;
			end
			if (meas.playing && meas.supply_valid) begin
				supply_voltage_level_q <= meas.supply;
			end
		end
	end

	// Read data selection; unmapped addresses read zero
	assign rdata_d = hit(bus_req.addr, `HSIRQ_ADDR_STATUS)    ? status_word :
	                 hit(bus_req.addr, `HSIRQ_ADDR_MASK)      ? {mask_rsv_q, irq_suppress_bits_q} :
	                 hit(bus_req.addr, `HSIRQ_ADDR_IMPEDANCE) ? actuator_impedance_result_q :
	                 hit(bus_req.addr, `HSIRQ_ADDR_SUPPLY)    ? supply_voltage_level_q : 8'h00;

	// Read data register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (ce && bus_req.rd) begin
			rdata_q <= rdata_d;
		end
	end

	// Assertions
	property p_read_clears_done;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && status_rd && !events.done) |=> !done_flag;
	endproperty
	a_read_clears_done: assert property (p_read_clears_done) else $error("completion flag not cleared by read");

	property p_droop_sticky;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && events.supply_droop) ##1 (!status_rd && !(ce && status_rd))[*2] |-> supply_droop_flag;
	endproperty
	a_droop_sticky: assert property (p_droop_sticky) else $error("droop flag lost without read");

	property p_thermal_set;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && events.thermal) |=> thermal_flag;
	endproperty
	a_thermal_set: assert property (p_thermal_set) else $error("thermal flag not set");

	property p_oc_hold;
		@(posedge clk_sys) disable iff (!rstn)
		(output_overcurrent_flag && !status_rd) |=> output_overcurrent_flag;
	endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag dropped");

	property p_mask_suppress;
		@(posedge clk_sys) disable iff (!rstn)
		((|(status_word[4:0] & irq_suppress_bits_q)) && ((status_word[4:0] & ~irq_suppress_bits_q) == 5'h00))
			|-> !trigger_irq_pin_oe;
	endproperty
	a_mask_suppress: assert property (p_mask_suppress) else $error("masked flag raised interrupt");

	property p_mode_gate;
		@(posedge clk_sys) disable iff (!rstn)
		(pin_func != hsirq_pkg::HSIRQ_PIN_IRQ) |-> !trigger_irq_pin_oe;
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("interrupt outside interrupt mode");

	property p_imp_update;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && meas.impedance_valid) |=> (actuator_impedance_result_q == $past(meas.impedance));
	endproperty
	a_imp_update: assert property (p_imp_update) else $error("impedance not captured");

	property p_supply_frozen;
		@(posedge clk_sys) disable iff (!rstn)
		!meas.playing |=> $stable(supply_voltage_level_q);
	endproperty
	a_supply_frozen: assert property (p_supply_frozen) else $error("supply changed while idle");

	property p_ram_irq;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && events.ram_format_error && irq_mode && !irq_suppress_bits_q[4] && !mask_wr)
			|=> (trigger_irq_pin_oe || !irq_mode);
	endproperty
	a_ram_irq: assert property (p_ram_irq) else $error("ram error gave no interrupt");

	property p_diag_set;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && events.diag_fail) |=> (diag_fail_flag && status_word[7]);
	endproperty
	a_diag_set: assert property (p_diag_set) else $error("diag fail flag not set");

	property p_pin_release;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && status_rd && events == '0 && irq_mode) |=> (!trigger_irq_pin_oe || !$stable(pin_func));
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin not released after read");

	property p_set_wins;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && status_rd && events.done) |=> done_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("completion lost to coinciding read");

	property p_done_set;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && events.done) |=> (done_flag && status_word[`HSIRQ_BIT_DONE]);
	endproperty
	a_done_set: assert property (p_done_set) else $error("completion flag not set");

	property p_droop_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && status_rd && !events.supply_droop) |=> !status_word[`HSIRQ_BIT_DROOP];
	endproperty
	a_droop_clear: assert property (p_droop_clear) else $error("droop flag not cleared by read");

	property p_thermal_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && status_rd && !events.thermal) |=> !status_word[`HSIRQ_BIT_THERMAL];
	endproperty
	a_thermal_clear: assert property (p_thermal_clear) else $error("thermal flag not cleared by read");

	property p_oc_set;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && events.overcurrent) |=> status_word[`HSIRQ_BIT_OVERCURRENT];
	endproperty
	a_oc_set: assert property (p_oc_set) else $error("overcurrent flag not set");

	property p_mask_write;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && mask_wr) |=> (irq_suppress_bits_q == $past(bus_req.wdata[4:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

	property p_unmasked_irq;
		@(posedge clk_sys) disable iff (!rstn)
		(irq_mode && ((status_word[4:0] & ~irq_suppress_bits_q) != 5'h00)) |-> (trigger_irq_pin_oe && !trigger_irq_pin_o);
	endproperty
	a_unmasked_irq: assert property (p_unmasked_irq) else $error("unmasked flag gave no interrupt");

	property p_read_impedance;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && bus_req.rd && (bus_req.addr == `HSIRQ_ADDR_IMPEDANCE))
			|=> (rdata_q == $past(actuator_impedance_result_q));
	endproperty
	a_read_impedance: assert property (p_read_impedance) else $error("impedance read data wrong");

	property p_supply_capture;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && meas.playing && meas.supply_valid) |=> (supply_voltage_level_q == $past(meas.supply));
	endproperty
	a_supply_capture: assert property (p_supply_capture) else $error("supply not captured while playing");

	property p_ram_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && status_rd && !events.ram_format_error) |=> !status_word[`HSIRQ_BIT_RAM_ERR];
	endproperty
	a_ram_clear: assert property (p_ram_clear) else $error("ram error flag not cleared by read");

	property p_diag_clear;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && status_rd && !events.diag_fail) |=> !status_word[`HSIRQ_BIT_DIAG_FAIL];
	endproperty
	a_diag_clear: assert property (p_diag_clear) else $error("diag fail flag not cleared by read");

	property p_freeze;
		@(posedge clk_sys) disable iff (!rstn)
		!ce |=> ($stable(status_word) && $stable(rdata_q) && $stable(irq_suppress_bits_q));
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

endmodule : hsirq_regs

// *** verilog/hsirq_sticky.sv ***
// Sticky status flag: set by a hardware event, cleared by a status read.
// Assumes clear is a single-cycle read strobe; set wins over clear.
`timescale 1ns/1ps

module hsirq_sticky (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_q
);

	logic flag_d;

	// Set has priority so an event coinciding with the clearing read is kept
	assign flag_d = set | (flag_q & ~clr);

	// Flag storage
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			flag_q <= 1'b0;
		end else if (ce) begin
			flag_q <= flag_d;
		end
	end

endmodule : hsirq_sticky
